/* File: hw/rtcs_ctrl.sv */
`timescale 1ns/100ps
`include "rtcs_defines.svh"
// What this block does
// - Three-bit periodic select; 000 keeps output high, 001 holds it low.
// - Codes 010 and 011 give 2 Hz and 1 Hz half-duty squares.
// - Level codes fire each second, minute, hour or month start.
// - Level mode: seconds increment coincides with the output falling edge.
// - Adjustment shifts the cycle by up to 3.784 ms every 20 s.
// - Pulse mode: seconds increment lags the falling edge by 92 us.
// - A seconds write clears the divider; in pulse and level modes it drives the output low.
// - Threshold select: 0 picks 2.1 V, 1 picks 1.6 V.
// - Supply-low flag latches at 1 and monitoring stops.
// - Writing 0 clears supply-low and restarts monitoring; 1 does nothing.
// - Spare bit one stores data; forced to 0 while halt flag is set.
// - Halt sensing only works while chip enable is low.
// - Halt flag sets when the crystal stops and stays set afterwards.
// - Halt flag clears adjustment and control bits, stops irq, runs clock.
// - Writing 0 clears halt flag and re-arms sensing; 1 does nothing.
// - Clock output runs if either disable bit is 0, high if both 1.
// - Without clock control, that bit is spare storage cleared on halt.
// - Periodic flag reads 1 while the periodic source pulls output low.
// - Level mode: writing 0 to periodic flag releases output until next.
// - Alarm flag sets 61 us after a match when its enable is 1.
// - Writing 0 to an alarm flag clears it; 1 does nothing.
// - Alarm flag reads 0 while its enable is 0.
// - Periodic select sits in bits 2..0 of control register at E.
// - Alarm enable bits switch their alarm circuits on and off.
module rtcs_ctrl #(
    parameter int SEC_LAG_CYC = `RTCS_SEC_LAG_CYC,
    parameter int ALARM_LAG_CYC = `RTCS_ALARM_LAG_CYC,
    parameter bit CLKOUT_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire rtcs_pkg::rtcs_addr_t reg_addr,
    input wire rtcs_pkg::rtcs_byte_t reg_wr_data,
    output rtcs_pkg::rtcs_byte_t reg_rd_data,
    // Pins
    input wire logic osc_in,
    input wire logic chip_enable,
    input wire logic osc_halt_detect,
    input wire logic supply_below_2v1,
    input wire logic supply_below_1v6,
    output logic irq_out_n,
    output logic slow_clock_out,
    // Timekeeping counters
    input wire logic roll_minute,
    input wire logic roll_hour,
    input wire logic roll_month,
    input wire logic weekly_alarm_match,
    input wire logic daily_alarm_match,
    input wire logic adj_lengthen,
    input wire logic adj_shorten,
    output logic seconds_inc,
    output logic adjust_clear,
    output logic hour_mode_24,
    output logic test_mode,
    output logic supply_monitor_on
);
    import rtcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [4:0] pins_sync;
    logic osc_s;
    logic ce_s;
    logic halt_s;
    logic low_2v1_s;
    logic low_1v6_s;

    rtcs_sync3 #(.W(5)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in({osc_in, chip_enable, osc_halt_detect,
            supply_below_2v1, supply_below_1v6}),
        .pin_sync(pins_sync)
    );
    assign {osc_s, ce_s, halt_s, low_2v1_s, low_1v6_s} = pins_sync;

    logic osc_prev_ff;
    logic osc_tick;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_s;
        end
    end
    assign osc_tick = osc_s && !osc_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    rtcs_byte_t ctrl1_ff;
    logic thr_sel_ff;
    logic supply_low_ff;
    logic spare1_ff;
    logic halt_ff;
    logic clkdis_a_ff;
    logic level_flag_ff;
    logic [1:0] alarm_flag_ff;
    logic wr_c1;
    logic wr_c2;
    logic wr_sec;
    logic [2:0] sel;
    rtcs_wave_t wave;

    assign wr_c1 = reg_wr_en && (reg_addr == `RTCS_ADDR_CTRL1);
    assign wr_c2 = reg_wr_en && (reg_addr == `RTCS_ADDR_CTRL2);
    assign wr_sec = reg_wr_en && (reg_addr == `RTCS_ADDR_SECONDS);
    assign sel = ctrl1_ff[`RTCS_C1_SEL_HI:`RTCS_C1_SEL_LO];

    always_comb begin
        case (sel)
            `RTCS_SEL_OFF: wave = RTCS_WAVE_OFF;
            `RTCS_SEL_LOW: wave = RTCS_WAVE_LOW;
            `RTCS_SEL_2HZ, `RTCS_SEL_1HZ: wave = RTCS_WAVE_PULSE;
            default: wave = RTCS_WAVE_LEVEL;
        endcase
    end

    // Halt flag wipes the rest of both control registers every cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst || halt_ff) begin
            ctrl1_ff <= `RTCS_C1_RESET;
        end else if (wr_c1) begin
            ctrl1_ff <= reg_wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || halt_ff) begin
            thr_sel_ff <= 1'b0;
            spare1_ff <= 1'b0;
            clkdis_a_ff <= 1'b0;
        end else if (wr_c2) begin
            thr_sel_ff <= reg_wr_data[`RTCS_C2_THR_SEL];
            spare1_ff <= reg_wr_data[`RTCS_C2_SPARE1];
            clkdis_a_ff <= reg_wr_data[`RTCS_C2_CLKDIS_A];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillation halt sensing
    // Detection wins over a write of 0 landing in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            halt_ff <= 1'b1;
        end else if (halt_s && !ce_s) begin
            halt_ff <= 1'b1;
        end else if (wr_c2 && !reg_wr_data[`RTCS_C2_HALT]) begin
            halt_ff <= 1'b0;
        end
    end
    assign adjust_clear = halt_ff;

    ////////////////////////////////////////////////////////////////////////
    // Supply monitor
    logic supply_low_now;
    assign supply_low_now = thr_sel_ff ? low_1v6_s : low_2v1_s;
    assign supply_monitor_on = !supply_low_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst || halt_ff) begin
            supply_low_ff <= 1'b0;
        end else if (supply_low_now && !supply_low_ff) begin
            supply_low_ff <= 1'b1;
        end else if (wr_c2 && !reg_wr_data[`RTCS_C2_SUPPLY_LOW]) begin
            supply_low_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sub-second divider and seconds increment
    logic [`RTCS_SUBSEC_W-1:0] phase;
    logic wrap;

    rtcs_subsec u_subsec (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .osc_tick(osc_tick),
        .clear(wr_sec),
        .adj_lengthen(adj_lengthen && !halt_ff),
        .adj_shorten(adj_shorten && !halt_ff),
        .phase_ff(phase),
        .wrap(wrap)
    );

    // Pulse mode delays the increment so readers see a stable edge first
    logic [`RTCS_LAG_W-1:0] sec_lag_ff;
    logic sec_lag_busy_ff;
    logic seconds_inc_ff;
    always_ff @(posedge core_clk) begin
        if (sys_rst || wr_sec) begin
            sec_lag_ff <= '0;
            sec_lag_busy_ff <= 1'b0;
            seconds_inc_ff <= 1'b0;
        end else if (wrap && wave != RTCS_WAVE_PULSE) begin
            seconds_inc_ff <= 1'b1;
        end else if (wrap) begin
            sec_lag_ff <= `RTCS_LAG_W'(SEC_LAG_CYC - 1);
            sec_lag_busy_ff <= 1'b1;
            seconds_inc_ff <= 1'b0;
        end else if (sec_lag_busy_ff && sec_lag_ff == '0) begin
            sec_lag_busy_ff <= 1'b0;
            seconds_inc_ff <= 1'b1;
        end else begin
            if (sec_lag_busy_ff) begin
                sec_lag_ff <= sec_lag_ff - `RTCS_LAG_W'(1);
            end
            seconds_inc_ff <= 1'b0;
        end
    end
    assign seconds_inc = seconds_inc_ff;

    ////////////////////////////////////////////////////////////////////////
    // Periodic interrupt source
    logic pulse_low;
    logic level_hit;
    always_comb begin
        case (sel)
            `RTCS_SEL_2HZ: pulse_low = !phase[`RTCS_SUBSEC_W-2];
            `RTCS_SEL_1HZ: pulse_low = !phase[`RTCS_SUBSEC_W-1];
            default: pulse_low = 1'b0;
        endcase
    end

    always_comb begin
        case (sel)
            `RTCS_SEL_SEC: level_hit = 1'b1;
            `RTCS_SEL_MIN: level_hit = roll_minute;
            `RTCS_SEL_HOUR: level_hit = roll_hour;
            `RTCS_SEL_MONTH: level_hit = roll_month;
            default: level_hit = 1'b0;
        endcase
    end

    // Level latch rises with the second boundary; a new cycle beats a clear
    always_ff @(posedge core_clk) begin
        if (sys_rst || halt_ff || wave != RTCS_WAVE_LEVEL) begin
            level_flag_ff <= 1'b0;
        end else if (wr_sec) begin
            level_flag_ff <= 1'b1;
        end else if (wrap && level_hit) begin
            level_flag_ff <= 1'b1;
        end else if (wr_c2 && !reg_wr_data[`RTCS_C2_PERIODIC]) begin
            level_flag_ff <= 1'b0;
        end
    end

    logic periodic_low;
    always_comb begin
        case (wave)
            RTCS_WAVE_OFF: periodic_low = 1'b0;
            RTCS_WAVE_LOW: periodic_low = 1'b1;
            RTCS_WAVE_PULSE: periodic_low = pulse_low;
            RTCS_WAVE_LEVEL: periodic_low = level_flag_ff;
            default: periodic_low = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm flags, weekly at index 1, daily at index 0
    logic [1:0] alarm_en;
    logic [1:0] alarm_match;
    assign alarm_en = {ctrl1_ff[`RTCS_C1_WEEK_EN], ctrl1_ff[`RTCS_C1_DAY_EN]};
    assign alarm_match = {weekly_alarm_match, daily_alarm_match};

    genvar a;
    generate
        for (a = 0; a < 2; a++) begin : g_alarm
            logic [`RTCS_LAG_W-1:0] lag_ff;
            logic busy_ff;
            logic fire;
            assign fire = busy_ff && (lag_ff == '0);

            always_ff @(posedge core_clk) begin
                if (sys_rst || !alarm_en[a]) begin
                    lag_ff <= '0;
                    busy_ff <= 1'b0;
                end else if (alarm_match[a]) begin
                    lag_ff <= `RTCS_LAG_W'(ALARM_LAG_CYC - 1);
                    busy_ff <= 1'b1;
                end else if (fire) begin
                    busy_ff <= 1'b0;
                end else if (busy_ff) begin
                    lag_ff <= lag_ff - `RTCS_LAG_W'(1);
                end
            end

            // Enable low holds the flag at 0, so it reads 0 too
            always_ff @(posedge core_clk) begin
                if (sys_rst || !alarm_en[a]) begin
                    alarm_flag_ff[a] <= 1'b0;
                end else if (fire) begin
                    alarm_flag_ff[a] <= 1'b1;
                end else if (wr_c2 && !reg_wr_data[a]) begin
                    alarm_flag_ff[a] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs
    logic clk_run;
    assign clk_run = !CLKOUT_VARIANT || halt_ff ||
        !(clkdis_a_ff && ctrl1_ff[`RTCS_C1_CLKDIS_B]);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= !(periodic_low || (|alarm_flag_ff));
        end
    end

    // Held high when stopped; follows the crystal otherwise
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            slow_clock_out <= 1'b1;
        end else begin
            slow_clock_out <= clk_run ? osc_s : 1'b1;
        end
    end

    assign hour_mode_24 = ctrl1_ff[`RTCS_C1_HOUR24];
    assign test_mode = ctrl1_ff[`RTCS_C1_TEST];

    ////////////////////////////////////////////////////////////////////////
    // Register read-back
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `RTCS_ADDR_CTRL1: reg_rd_data <= ctrl1_ff;
                `RTCS_ADDR_CTRL2: reg_rd_data <= {thr_sel_ff, supply_low_ff,
                    spare1_ff, halt_ff, clkdis_a_ff, periodic_low,
                    alarm_flag_ff};
                default: reg_rd_data <= 8'h00;
            endcase
        end
    end
endmodule : rtcs_ctrl

/* File: hw/rtcs_subsec.sv */
`timescale 1ns/100ps
`include "rtcs_defines.svh"
// Sub-second divider clocked by oscillator tick enables
module rtcs_subsec (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control
    input wire logic osc_tick,
    input wire logic clear,
    input wire logic adj_lengthen,
    input wire logic adj_shorten,
    // Phase outputs
    output logic [`RTCS_SUBSEC_W-1:0] phase_ff,
    output logic wrap
);
    logic [7:0] stall_ff;
    logic lengthen_ff;
    logic shorten_ff;

    assign wrap = osc_tick && (stall_ff == 8'h00) && (&phase_ff);

    // Adjustment requests wait for the next second boundary
    always_ff @(posedge core_clk) begin
        if (sys_rst || clear) begin
            lengthen_ff <= 1'b0;
            shorten_ff <= 1'b0;
        end else if (wrap) begin
            lengthen_ff <= adj_lengthen;
            shorten_ff <= adj_shorten;
        end else begin
            lengthen_ff <= lengthen_ff | adj_lengthen;
            shorten_ff <= shorten_ff | adj_shorten;
        end
    end

    // Shifts land at the start of the low half so the boundary stays clean
    always_ff @(posedge core_clk) begin
        if (sys_rst || clear) begin
            phase_ff <= '0;
            stall_ff <= 8'h00;
        end else if (osc_tick) begin
            if (stall_ff != 8'h00) begin
                stall_ff <= stall_ff - 8'h01;
            end else if (wrap && shorten_ff) begin
                phase_ff <= `RTCS_SUBSEC_W'(`RTCS_ADJ_TICKS);
            end else if (wrap && lengthen_ff) begin
                phase_ff <= '0;
                stall_ff <= 8'(`RTCS_ADJ_TICKS);
            end else begin
                phase_ff <= phase_ff + `RTCS_SUBSEC_W'(1);
            end
        end
    end
endmodule : rtcs_subsec

/* File: hw/rtcs_sync3.sv */
`timescale 1ns/100ps
// Three-stage pin synchroniser; output moves once stages two and three agree
module rtcs_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Pins and synchronised levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] mid_ff;
    logic [W-1:0] last_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            mid_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= pin_in;
            mid_ff <= meta_ff;
            last_ff <= mid_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_agree
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    pin_sync[i] <= 1'b0;
                end else if (mid_ff[i] == last_ff[i]) begin
                    pin_sync[i] <= last_ff[i];
                end
            end
        end
    endgenerate
endmodule : rtcs_sync3

/* File: include/rtcs_defines.svh */
`ifndef RTCS_DEFINES_SVH
`define RTCS_DEFINES_SVH
// Register indices on the four-wire register port
`define RTCS_ADDR_SECONDS 4'h0
`define RTCS_ADDR_CTRL1 4'hE
`define RTCS_ADDR_CTRL2 4'hF
// Control register 1 fields
`define RTCS_C1_WEEK_EN 7
`define RTCS_C1_DAY_EN 6
`define RTCS_C1_HOUR24 5
`define RTCS_C1_CLKDIS_B 4
`define RTCS_C1_TEST 3
`define RTCS_C1_SEL_HI 2
`define RTCS_C1_SEL_LO 0
`define RTCS_C1_RESET 8'h00
// Control register 2 fields
`define RTCS_C2_THR_SEL 7
`define RTCS_C2_SUPPLY_LOW 6
`define RTCS_C2_SPARE1 5
`define RTCS_C2_HALT 4
`define RTCS_C2_CLKDIS_A 3
`define RTCS_C2_PERIODIC 2
`define RTCS_C2_WEEK_FLAG 1
`define RTCS_C2_DAY_FLAG 0
`define RTCS_C2_RESET 8'h10
// Periodic selection codes
`define RTCS_SEL_OFF 3'h0
`define RTCS_SEL_LOW 3'h1
`define RTCS_SEL_2HZ 3'h2
`define RTCS_SEL_1HZ 3'h3
`define RTCS_SEL_SEC 3'h4
`define RTCS_SEL_MIN 3'h5
`define RTCS_SEL_HOUR 3'h6
`define RTCS_SEL_MONTH 3'h7
// Timing
`define RTCS_CLK_MHZ 100
`define RTCS_SEC_LAG_US 92
`define RTCS_SEC_LAG_CYC (`RTCS_SEC_LAG_US * `RTCS_CLK_MHZ)
`define RTCS_ALARM_LAG_US 61
`define RTCS_ALARM_LAG_CYC (`RTCS_ALARM_LAG_US * `RTCS_CLK_MHZ)
`define RTCS_OSC_HZ 32768
`define RTCS_ADJ_SHIFT_US 3784
`define RTCS_ADJ_TICKS ((`RTCS_ADJ_SHIFT_US * `RTCS_OSC_HZ) / 1000000)
`define RTCS_SUBSEC_W 15
`define RTCS_LAG_W 14
`endif

/* File: include/rtcs_pkg.sv */
package rtcs_pkg;
    typedef enum logic [3:0] {
        RTCS_WAVE_OFF = 4'h1,
        RTCS_WAVE_LOW = 4'h2,
        RTCS_WAVE_PULSE = 4'h4,
        RTCS_WAVE_LEVEL = 4'h8
    } rtcs_wave_t;
    typedef logic [7:0] rtcs_byte_t;
    typedef logic [3:0] rtcs_addr_t;
endpackage : rtcs_pkg

/* File: sim/rtc_interrupt_status_control_bench.sv */
`timescale 1ns/100ps
module rtc_interrupt_status_control_bench;
    import rtcs_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc_in = 1'b0;
    logic chip_enable = 1'b1;
    logic osc_halt_detect = 1'b0;
    logic supply_below_2v1 = 1'b0;
    logic supply_below_1v6 = 1'b0;
    logic weekly_alarm_match = 1'b0;
    logic daily_alarm_match = 1'b0;
    logic zero = 1'b0;
    logic reg_wr_en, reg_rd_en, irq_out_n, slow_clock_out, seconds_inc;
    logic adjust_clear, hour_mode_24, test_mode, supply_monitor_on;
    rtcs_addr_t reg_addr;
    rtcs_byte_t reg_wr_data, reg_rd_data;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    rtcs_host host (.core_clk(core_clk), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
    // Short lags keep alarm scenarios brief
    rtcs_ctrl #(.SEC_LAG_CYC(5), .ALARM_LAG_CYC(5), .CLKOUT_VARIANT(1'b1))
    dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .osc_in(osc_in), .chip_enable(chip_enable),
        .osc_halt_detect(osc_halt_detect),
        .supply_below_2v1(supply_below_2v1),
        .supply_below_1v6(supply_below_1v6), .irq_out_n(irq_out_n),
        .slow_clock_out(slow_clock_out), .roll_minute(zero),
        .roll_hour(zero), .roll_month(zero),
        .weekly_alarm_match(weekly_alarm_match),
        .daily_alarm_match(daily_alarm_match), .adj_lengthen(zero),
        .adj_shorten(zero), .seconds_inc(seconds_inc),
        .adjust_clear(adjust_clear), .hour_mode_24(hour_mode_24),
        .test_mode(test_mode), .supply_monitor_on(supply_monitor_on));
    ////////////////////////////////////////////////////////////////////////
    initial forever #5 core_clk = ~core_clk;
    // Crystal sped up; the divider never wraps in this run
    initial forever #500 osc_in = ~osc_in;
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input rtcs_byte_t s, input rtcs_byte_t e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic pin(input string n, input logic s, input logic e);
        chk(n, {7'h00, s}, {7'h00, e});
    endtask : pin
    task automatic rdchk(input rtcs_addr_t a, input rtcs_byte_t e);
        rtcs_byte_t d;
        host.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask : rdchk
    task automatic w(input int n);
        repeat (n) @(negedge core_clk);
    endtask : w
    task automatic hit(input logic wk);
        @(negedge core_clk);
        weekly_alarm_match = wk;
        daily_alarm_match = !wk;
        @(negedge core_clk);
        weekly_alarm_match = 1'b0;
        daily_alarm_match = 1'b0;
    endtask : hit
    task automatic runs(input logic e);
        logic p;
        int n;
        n = 0;
        p = slow_clock_out;
        repeat (300) begin
            @(negedge core_clk);
            if (slow_clock_out !== p) n++;
            p = slow_clock_out;
        end
        pin("clk runs", n != 0, e);
    endtask : runs
    ////////////////////////////////////////////////////////////////////////
    initial begin
        w(10);
        sys_rst = 1'b0;
        rdchk(4'hF, 8'h10);
        rdchk(4'h7, 8'h00);
        rdchk(4'hE, 8'h00);
        host.wr(4'hE, 8'h07);
        rdchk(4'hE, 8'h00);
        host.wr(4'hF, 8'h10);
        rdchk(4'hF, 8'h10);
        host.wr(4'hF, 8'h00);
        rdchk(4'hF, 8'h00);
        $display("done: reset and halt clear");
        host.wr(4'hE, 8'h01);
        w(3);
        pin("irq", irq_out_n, 1'b0);
        rdchk(4'hF, 8'h04);
        host.wr(4'hE, 8'h00);
        w(3);
        pin("irq", irq_out_n, 1'b1);
        host.wr(4'hE, 8'h04);
        host.wr(4'h0, 8'h00);
        w(3);
        pin("irq", irq_out_n, 1'b0);
        rdchk(4'hF, 8'h04);
        host.wr(4'hF, 8'h04);
        pin("irq", irq_out_n, 1'b0);
        host.wr(4'hF, 8'h00);
        w(3);
        pin("irq", irq_out_n, 1'b1);
        host.wr(4'hE, 8'h02);
        host.wr(4'h0, 8'h00);
        w(3);
        pin("irq", irq_out_n, 1'b0);
        pin("sec inc", seconds_inc, 1'b0);
        host.wr(4'hE, 8'h00);
        $display("done: periodic");
        host.wr(4'hF, 8'hA0);
        rdchk(4'hF, 8'hA0);
        supply_below_2v1 = 1'b1;
        w(8);
        rdchk(4'hF, 8'hA0);
        supply_below_1v6 = 1'b1;
        w(8);
        rdchk(4'hF, 8'hE0);
        pin("monitor", supply_monitor_on, 1'b0);
        supply_below_1v6 = 1'b0;
        supply_below_2v1 = 1'b0;
        w(8);
        host.wr(4'hF, 8'hE0);
        rdchk(4'hF, 8'hE0);
        host.wr(4'hF, 8'hA0);
        rdchk(4'hF, 8'hA0);
        pin("monitor", supply_monitor_on, 1'b1);
        host.wr(4'hF, 8'h00);
        supply_below_2v1 = 1'b1;
        w(8);
        rdchk(4'hF, 8'h40);
        supply_below_2v1 = 1'b0;
        w(8);
        host.wr(4'hF, 8'h00);
        $display("done: supply monitor");
        host.wr(4'hE, 8'h40);
        hit(1'b0);
        w(2);
        pin("irq", irq_out_n, 1'b1);
        w(6);
        pin("irq", irq_out_n, 1'b0);
        rdchk(4'hF, 8'h01);
        hit(1'b1);
        w(10);
        rdchk(4'hF, 8'h01);
        host.wr(4'hF, 8'h01);
        rdchk(4'hF, 8'h01);
        host.wr(4'hF, 8'h00);
        w(2);
        pin("irq", irq_out_n, 1'b1);
        hit(1'b0);
        w(10);
        host.wr(4'hE, 8'h00);
        rdchk(4'hF, 8'h00);
        pin("irq", irq_out_n, 1'b1);
        host.wr(4'hE, 8'h80);
        hit(1'b1);
        w(10);
        rdchk(4'hF, 8'h02);
        host.wr(4'hF, 8'h00);
        host.wr(4'hE, 8'h00);
        $display("done: alarms");
        runs(1'b1);
        host.wr(4'hE, 8'h10);
        runs(1'b1);
        host.wr(4'hF, 8'h08);
        w(3);
        runs(1'b0);
        pin("clk level", slow_clock_out, 1'b1);
        $display("done: clock output");
        host.wr(4'hF, 8'h28);
        host.wr(4'hE, 8'h2F);
        osc_halt_detect = 1'b1;
        w(8);
        rdchk(4'hF, 8'h28);
        pin("hour24", hour_mode_24, 1'b1);
        pin("test", test_mode, 1'b1);
        chip_enable = 1'b0;
        w(8);
        osc_halt_detect = 1'b0;
        w(8);
        rdchk(4'hF, 8'h10);
        rdchk(4'hE, 8'h00);
        pin("adj clear", adjust_clear, 1'b1);
        pin("hour24", hour_mode_24, 1'b0);
        pin("test", test_mode, 1'b0);
        pin("irq", irq_out_n, 1'b1);
        runs(1'b1);
        host.wr(4'hF, 8'h00);
        rdchk(4'hF, 8'h00);
        $display("done: halt");
        report_and_stop();
    end
endmodule : rtc_interrupt_status_control_bench

/* File: sim/rtcs_ctrl_props.sv */
`timescale 1ns/100ps
module rtcs_ctrl_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire rtcs_pkg::rtcs_addr_t reg_addr,
    input wire rtcs_pkg::rtcs_byte_t reg_wr_data,
    input wire rtcs_pkg::rtcs_byte_t reg_rd_data,
    // Pins
    input wire logic chip_enable,
    input wire logic osc_halt_detect,
    input wire logic supply_below_2v1,
    input wire logic supply_below_1v6,
    input wire logic irq_out_n,
    input wire logic seconds_inc,
    input wire logic adjust_clear,
    input wire logic supply_monitor_on
);
    import rtcs_pkg::*;
    // History covers the three-stage pin synchroniser plus margin
    logic [7:0] halt_hist_ff;
    logic [7:0] pin_hist_ff;
    logic rd_valid_ff;
    logic wr_f;
    assign wr_f = reg_wr_en && reg_addr == 4'hF;
    always_ff @(posedge core_clk) begin
        halt_hist_ff <= {halt_hist_ff[6:0], osc_halt_detect && !chip_enable};
        pin_hist_ff <= {pin_hist_ff[6:0], osc_halt_detect};
        rd_valid_ff <= reg_rd_en && reg_addr == 4'hF && !sys_rst;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    rd_stable_a: assert property (!reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (reg_rd_en &&
        reg_addr inside {[4'h1:4'hD]} |=> reg_rd_data == 8'h00)
        else $error("unmapped address read nonzero");
    rst_idle_a: assert property ($fell(sys_rst) |-> irq_out_n &&
        !seconds_inc && reg_rd_data == 8'h00)
        else $error("outputs not idle after reset");
    flag_irq_a: assert property (rd_valid_ff &&
        reg_rd_data[2:0] != 3'h0 |-> ##[0:2] !irq_out_n)
        else $error("flag set but interrupt not low");
    halt_rise_a: assert property ($rose(adjust_clear) |->
        halt_hist_ff != 8'h00)
        else $error("halt flag set without sensed halt");
    halt_sticky_a: assert property (adjust_clear &&
        !(wr_f && !reg_wr_data[4]) |=> adjust_clear)
        else $error("halt flag dropped without write of 0");
    monitor_latch_a: assert property (!supply_monitor_on &&
        !(wr_f && !reg_wr_data[6]) && pin_hist_ff == 8'h00 &&
        !osc_halt_detect |=> !supply_monitor_on)
        else $error("supply monitor restarted by itself");
    monitor_restart_a: assert property (wr_f && !reg_wr_data[6] &&
        !supply_below_2v1 && !supply_below_1v6 |-> ##[1:3] supply_monitor_on)
        else $error("supply monitor not restarted");
    cover property (rd_valid_ff && reg_rd_data[2]);
    cover property ($fell(supply_monitor_on));
    cover property ($rose(adjust_clear));
endmodule : rtcs_ctrl_props
bind rtcs_ctrl rtcs_ctrl_props chk (.*);

/* File: sim/rtcs_host.sv */
`timescale 1ns/100ps
module rtcs_host (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output rtcs_pkg::rtcs_addr_t reg_addr,
    output rtcs_pkg::rtcs_byte_t reg_wr_data,
    input wire rtcs_pkg::rtcs_byte_t reg_rd_data
);
    import rtcs_pkg::*;
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 4'h0;
        reg_wr_data = 8'h00;
    end
    // Flags are cleared by writing 0 to them; alarm flags also clear while their enable is 0
    task automatic wr(input rtcs_addr_t a, input rtcs_byte_t d);
        @(negedge core_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
        // Released bus must not keep showing the old data
        reg_wr_data = ~d;
    endtask : wr
    task automatic rd(input rtcs_addr_t a, output rtcs_byte_t d);
        @(negedge core_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        d = reg_rd_data;
    endtask : rd
endmodule : rtcs_host
